// File: dv/testbench.sv
// self-checking bench for the peripheral clock gate bank
// assumes pcg_pkg and pcg_gate_bank are compiled before it
`timescale 1ns/1ps
module testbench;
  import pcg_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic scanEn = 1'b0;
  pcg_req_t req = '0;
  logic [7:0] rdata;
  logic hit;
  pcg_access_t [23:0] periphAccess = '0;
  logic [23:0][7:0] periphRdata = '0;
  pcg_access_t [23:0] periphGrant;
  logic [23:0][7:0] periphRdataGated;
  logic [23:0] periphClk;
  logic [23:0] periphRstHold;
  logic subSourceSelect;
  logic xferRunAllow;
  logic rtcCountClkSel;
  int failures = 0;
  int samples_checked = 0;
  logic [7:0] lfsr = 8'h56;
  logic [7:0] en [3];
  logic [7:0] rs [3];
  logic [7:0] v;
  localparam logic [19:0] EA [3] = '{PCG_EN0_ADDR, PCG_EN1_ADDR, PCG_EN2_ADDR};
  localparam logic [19:0] RA [3] = '{PCG_RST0_ADDR, PCG_RST1_ADDR,
    PCG_RST2_ADDR};
  localparam logic [7:0] MK [3] = '{PCG_EN0_MASK, PCG_EN1_MASK, PCG_EN2_MASK};

  always #20 clk = ~clk;

  pcg_gate_bank dut (.clk(clk), .arst_n(arst_n), .scanEn(scanEn), .req(req),
    .rdata(rdata), .hit(hit), .periphAccess(periphAccess),
    .periphRdata(periphRdata), .periphGrant(periphGrant),
    .periphRdataGated(periphRdataGated), .periphClk(periphClk),
    .periphRstHold(periphRstHold), .subSourceSelect(subSourceSelect),
    .xferRunAllow(xferRunAllow), .rtcCountClkSel(rtcCountClkSel));

  function automatic logic [7:0] next_rand();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : next_rand

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [7:0] d,
                    input logic b, input logic [2:0] p);
    @(negedge clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, bitOp: b, bitPos: p, wdata: d};
    @(negedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [7:0] e,
                    input logic h);
    @(negedge clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, bitOp: 1'b0, bitPos: 3'h0,
             wdata: 8'h00};
    #5;
    chk(rdata, e, "register read");
    chk({7'h00, hit}, {7'h00, h}, "address hit");
  endtask : rd

  task automatic chkp();
    logic b;
    @(negedge clk);
    for (int g = 0; g < 24; g++) begin
      v = next_rand();
      periphAccess[g] <= v[1:0];
      periphRdata[g] <= next_rand();
    end
    #5;
    for (int g = 0; g < 24; g++) begin
      b = en[g / 8][g % 8];
      chk({6'h00, periphGrant[g]}, b ? {6'h00, periphAccess[g]} : 8'h00,
          "grant");
      chk(periphRdataGated[g], b ? periphRdata[g] : 8'h00,
          "gated read");
      chk({7'h00, periphRstHold[g]}, {7'h00, rs[g / 8][g % 8] |
          (g == PCG_FREQ_MEAS_IDX && !b)}, "reset hold");
    end
    chk({7'h00, xferRunAllow}, {7'h00, en[1][3]}, "xfer allow");
    @(posedge clk);
    #10;
    for (int g = 0; g < 24; g++)
      chk({7'h00, periphClk[g]}, {7'h00, en[g / 8][g % 8] | scanEn},
          "gated clock high phase");
  endtask : chkp

  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  initial begin
    en = '{default: 8'h00};
    rs = '{default: 8'h00};
    repeat (5) @(posedge clk);
    @(negedge clk) arst_n <= 1'b1;
    for (int i = 0; i < 3; i++) rd(EA[i], 8'h00, 1'b1);
    chkp();
    $display("test reset values done");
    repeat (6) begin
      for (int i = 0; i < 3; i++) begin
        v = next_rand();
        wr(EA[i], v, 1'b0, 3'h0);
        en[i] = v & MK[i];
        rd(EA[i], en[i], 1'b1);
      end
      chkp();
    end
    $display("test byte writes done");
    for (int k = 1; k >= 0; k--) begin
      for (int i = 0; i < 3; i++)
        for (int p = 0; p < 8; p++) begin
          wr(EA[i], {7'h00, k[0]}, 1'b1, p[2:0]);
          en[i][p] = k[0] & MK[i][p];
          rd(EA[i], en[i], 1'b1);
        end
      chkp();
    end
    $display("test bit writes done");
    // peripherals idle while their enables change
    @(negedge clk) periphAccess <= '0;
    for (int i = 0; i < 3; i++) begin
      en[i] = next_rand() & MK[i] & ~{7'h00, i == 2};
      rs[i] = next_rand() & MK[i];
      wr(EA[i], en[i], 1'b0, 3'h0);
      wr(RA[i], rs[i], 1'b0, 3'h0);
      rd(RA[i], rs[i], 1'b1);
    end
    chkp();
    rd(20'hF00F2, 8'h00, 1'b0);
    $display("test reset registers done");
    for (int k = 0; k < 3; k++) begin
      // cpu on main clock, sub oscillator idle
      wr(PCG_SUBSEL_ADDR, {7'h00, k[0]}, 1'b0, 3'h0);
      chk({7'h00, subSourceSelect}, {7'h00, k[0]}, "sub select");
      chk({7'h00, rtcCountClkSel}, {7'h00, k[0]}, "rtc source");
    end
    @(negedge clk) scanEn <= 1'b1;
    chkp();
    @(negedge clk) arst_n <= 1'b0;
    scanEn <= 1'b0;
    en = '{default: 8'h00};
    rs = '{default: 8'h00};
    @(negedge clk) arst_n <= 1'b1;
    for (int i = 0; i < 3; i++) rd(EA[i], 8'h00, 1'b1);
    chkp();
    $display("test second reset done");
    give_verdict();
  end
endmodule : testbench

// File: verilog/pcg_gate_bank.sv
// peripheral clock gate bank: enable, reset and subclock select registers
// assumes one cpu clock; peripheral access strobes decoded outside
`timescale 1ns/1ps
// Overview of operation
// RULE1: bank 0 holds seven enables, bit7 unused
// RULE2: bank 1 holds seven enables, bit7 unused
// RULE3: bank 2 holds six enables, bits 1,3 unused
// RULE4: any reset clears all enable registers
// RULE5: disabled: clock stopped, writes dropped, reads zero
// RULE6: enabled: clock runs, access passes normally
// RULE7: disabled frequency meter held in reset
// RULE8: transfer controller runs only when enabled
// RULE9: rtc keeps counting, access blocked when disabled
// RULE10: software keeps rtc enable low normally
// RULE11: software writes zero to unused bits
// RULE12: software enables before configuring peripheral
// RULE13: software changes enable only when stopped
// RULE14: bit and byte writes both accepted
// RULE15: companion reset registers, same bit positions
// RULE16: subclock select 0 sub, 1 low-speed osc
// RULE17: no low-speed select while sub clock runs
// RULE18: change select only with main cpu clock
// RULE19: latch-based glitch-free clock gate cells
module pcg_gate_bank (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // test bypass for the gating latches
  input wire logic scanEn,
  // register bus
  input wire pcg_pkg::pcg_req_t req,
  output logic [7:0] rdata,
  output logic hit,
  // peripheral side
  input wire pcg_pkg::pcg_access_t [23:0] periphAccess,
  input wire logic [23:0][7:0] periphRdata,
  output pcg_pkg::pcg_access_t [23:0] periphGrant,
  output logic [23:0][7:0] periphRdataGated,
  output logic [23:0] periphClk,
  output logic [23:0] periphRstHold,
  // clock status and select
  output logic subSourceSelect,
  output logic xferRunAllow,
  output logic rtcCountClkSel
);
  import pcg_pkg::*;

  logic [7:0] periph_clock_enable_0_reg;
  logic [7:0] periph_clock_enable_1_reg;
  logic [7:0] periph_clock_enable_2_reg;
  logic [7:0] periph_reset_0_reg;
  logic [7:0] periph_reset_1_reg;
  logic [7:0] periph_reset_2_reg;
  logic subSel_reg;
  logic [23:0] enAll;
  logic [23:0] rstAll;

  // merge a byte write or single-bit manipulation into a register
  function automatic logic [7:0] merge(input logic [7:0] cur,
    input pcg_req_t r, input logic [7:0] mask);
    logic [7:0] val;
    val = cur;
    if (r.bitOp) begin
      val[r.bitPos] = r.wdata[PCG_BITPOS_W];
    end else begin
      val = r.wdata;
    end
    return val & mask;
  endfunction : merge

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      periph_clock_enable_0_reg <= PCG_EN_RESET; // RULE4
      periph_clock_enable_1_reg <= PCG_EN_RESET; // RULE4
      periph_clock_enable_2_reg <= PCG_EN_RESET; // RULE4
    end else if (req.wr) begin
      if (req.addr == PCG_EN0_ADDR) begin
        periph_clock_enable_0_reg <=
          merge(periph_clock_enable_0_reg, req, PCG_EN0_MASK); // RULE1 RULE14
      end
      if (req.addr == PCG_EN1_ADDR) begin
        periph_clock_enable_1_reg <=
          merge(periph_clock_enable_1_reg, req, PCG_EN1_MASK); // RULE2 RULE14
      end
      if (req.addr == PCG_EN2_ADDR) begin
        periph_clock_enable_2_reg <=
          merge(periph_clock_enable_2_reg, req, PCG_EN2_MASK); // RULE3 RULE14
      end
    end
  end

  // reset registers mirror the enable bit positions
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      periph_reset_0_reg <= PCG_RST_RESET;
      periph_reset_1_reg <= PCG_RST_RESET;
      periph_reset_2_reg <= PCG_RST_RESET;
    end else if (req.wr) begin
      if (req.addr == PCG_RST0_ADDR) begin
        periph_reset_0_reg <=
          merge(periph_reset_0_reg, req, PCG_EN0_MASK); // RULE15
      end
      if (req.addr == PCG_RST1_ADDR) begin
        periph_reset_1_reg <=
          merge(periph_reset_1_reg, req, PCG_EN1_MASK); // RULE15
      end
      if (req.addr == PCG_RST2_ADDR) begin
        periph_reset_2_reg <=
          merge(periph_reset_2_reg, req, PCG_EN2_MASK); // RULE15
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      subSel_reg <= 1'b0;
    end else if (req.wr && req.addr == PCG_SUBSEL_ADDR) begin
      subSel_reg <= merge({7'h00, subSel_reg}, req, 8'h01) != 8'h00; // RULE16
    end
  end

  assign subSourceSelect = subSel_reg;
  assign rtcCountClkSel = subSel_reg; // RULE16
  assign enAll = {periph_clock_enable_2_reg, periph_clock_enable_1_reg,
    periph_clock_enable_0_reg};
  assign rstAll = {periph_reset_2_reg, periph_reset_1_reg,
    periph_reset_0_reg};
  assign xferRunAllow = enAll[PCG_XFER_IDX]; // RULE8

  // register read mux, unmapped addresses read zero
  always_comb begin
    hit = 1'b1;
    unique case (req.addr)
      PCG_EN0_ADDR: rdata = periph_clock_enable_0_reg;
      PCG_EN1_ADDR: rdata = periph_clock_enable_1_reg;
      PCG_EN2_ADDR: rdata = periph_clock_enable_2_reg;
      PCG_RST0_ADDR: rdata = periph_reset_0_reg;
      PCG_RST1_ADDR: rdata = periph_reset_1_reg;
      PCG_RST2_ADDR: rdata = periph_reset_2_reg;
      PCG_SUBSEL_ADDR: rdata = {7'h00, subSel_reg};
      default: begin
        rdata = 8'h00;
        hit = 1'b0;
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < PCG_NUM_PERIPH; g++) begin : gPer
      logic latchEn;
      // gate enable latched while clock low
      always_latch begin
        if (!clk) begin
          latchEn = enAll[g] | scanEn; // RULE19
        end
      end
      if (g == PCG_RTC_IDX) begin : gRtc
        // rtc counts from its own sub clock, only bus clock is gated
        assign periphClk[g] = clk & latchEn; // RULE9
      end else begin : gStd
        assign periphClk[g] = clk & latchEn; // RULE5 RULE6
      end
      assign periphGrant[g].wr = periphAccess[g].wr & enAll[g]; // RULE5 RULE6
      assign periphGrant[g].rd = periphAccess[g].rd & enAll[g];
      assign periphRdataGated[g] = enAll[g] ? periphRdata[g] : 8'h00; // RULE5
      if (g == PCG_FREQ_MEAS_IDX) begin : gFm
        assign periphRstHold[g] = rstAll[g] | ~enAll[g]; // RULE7
      end else begin : gRst
        assign periphRstHold[g] = rstAll[g]; // RULE15
      end
    end
  endgenerate

  chk_unused_zero: assert property (@(posedge clk) disable iff (!arst_n)
    periph_clock_enable_0_reg[7] == 1'b0 &&
    periph_clock_enable_1_reg[7] == 1'b0)
    else $error("unused enable bit set"); // RULE1
  chk_en1_write: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && !req.bitOp && req.addr == PCG_EN1_ADDR |=>
    periph_clock_enable_1_reg == ($past(req.wdata) & PCG_EN1_MASK))
    else $error("enable 1 byte write lost"); // RULE2
  chk_en2_unused: assert property (@(posedge clk) disable iff (!arst_n)
    periph_clock_enable_2_reg[3] == 1'b0 &&
    periph_clock_enable_2_reg[1] == 1'b0)
    else $error("enable 2 unused bit set"); // RULE3
  chk_reset_zero: assert property (@(posedge clk)
    $rose(arst_n) |-> enAll == 24'h000000)
    else $error("enables not clear after reset"); // RULE4
  chk_write_block: assert property (@(posedge clk) disable iff (!arst_n)
    !enAll[0] |-> !periphGrant[0].wr && periphRdataGated[0] == 8'h00)
    else $error("disabled peripheral accessed"); // RULE5
  chk_write_pass: assert property (@(posedge clk) disable iff (!arst_n)
    enAll[3] |-> periphGrant[3].wr == periphAccess[3].wr)
    else $error("enabled write not passed"); // RULE6
  chk_fm_reset: assert property (@(posedge clk) disable iff (!arst_n)
    !enAll[PCG_FREQ_MEAS_IDX] |-> periphRstHold[PCG_FREQ_MEAS_IDX])
    else $error("frequency meter not held"); // RULE7
  chk_xfer_run: assert property (@(posedge clk) disable iff (!arst_n)
    xferRunAllow == enAll[PCG_XFER_IDX])
    else $error("transfer run mismatch"); // RULE8
  chk_bit_write: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && req.bitOp && req.addr == PCG_EN0_ADDR && req.bitPos != 3'h7 |=>
    periph_clock_enable_0_reg[$past(req.bitPos)] == $past(req.wdata[0]))
    else $error("bit write lost"); // RULE14
  chk_subsel: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && !req.bitOp && req.addr == PCG_SUBSEL_ADDR |=>
    subSourceSelect == $past(req.wdata[0]))
    else $error("subclock select not stored"); // RULE16
  chk_rtc_block: assert property (@(posedge clk) disable iff (!arst_n)
    !enAll[PCG_RTC_IDX] |-> !periphGrant[PCG_RTC_IDX].wr)
    else $error("disabled rtc written"); // RULE9
  chk_rst_mirror: assert property (@(posedge clk) disable iff (!arst_n)
    periphRstHold[PCG_RTC_IDX] == periph_reset_2_reg[0])
    else $error("rtc reset hold mismatch"); // RULE15

  cov_enable_on: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(enAll[0]));
  cov_fm_release: cover property (@(posedge clk) disable iff (!arst_n)
    $fell(periphRstHold[PCG_FREQ_MEAS_IDX]));
  cov_lowspeed: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(subSourceSelect));
  cov_bit_write: cover property (@(posedge clk) disable iff (!arst_n)
    req.wr && req.bitOp && req.addr == PCG_EN2_ADDR);
  cov_rtc_open: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(enAll[PCG_RTC_IDX]));
endmodule : pcg_gate_bank

// File: verilog/pcg_pkg.sv
// package for the peripheral clock gate bank
// assumes an 8-bit special-register bus inside the clock generator
package pcg_pkg;
  localparam logic [19:0] PCG_EN0_ADDR = 20'hF00F0;
  localparam logic [19:0] PCG_EN1_ADDR = 20'hF00FA;
  localparam logic [19:0] PCG_EN2_ADDR = 20'hF00FC;
  localparam logic [19:0] PCG_RST0_ADDR = 20'hF00F1;
  localparam logic [19:0] PCG_RST1_ADDR = 20'hF00FB;
  localparam logic [19:0] PCG_RST2_ADDR = 20'hF00FD;
  localparam logic [19:0] PCG_SUBSEL_ADDR = 20'hFFFA7;
  localparam logic [7:0] PCG_EN_RESET = 8'h00;
  localparam logic [7:0] PCG_RST_RESET = 8'h00;
  localparam logic [7:0] PCG_EN0_MASK = 8'h7F;
  localparam logic [7:0] PCG_EN1_MASK = 8'h7F;
  localparam logic [7:0] PCG_EN2_MASK = 8'hF5;
  localparam int PCG_NUM_PERIPH = 24;
  localparam int PCG_FREQ_MEAS_IDX = 14;
  localparam int PCG_XFER_IDX = 11;
  localparam int PCG_RTC_IDX = 16;
  localparam logic [2:0] PCG_BITPOS_W = 3'h0;

  // one register access from the cpu
  typedef struct packed {
    logic [19:0] addr;
    logic wr;
    logic rd;
    logic bitOp;
    logic [2:0] bitPos;
    logic [7:0] wdata;
  } pcg_req_t;

  // cpu access forwarded to one peripheral's registers
  typedef struct packed {
    logic wr;
    logic rd;
  } pcg_access_t;
endpackage : pcg_pkg
